// *** hdl/rph_top.sv ***
// How it works
// - an 8-bit writable node address, zero after reset, is the address that received packets are screened against.
// - bit 7 of the packet configuration chooses variable length when set and fixed length when clear, fixed after reset.
// - the two-bit preamble field sends one to four preamble bytes for codes 00 to 11, three bytes after reset.
// - the whitening bit whitens sent data and dewhitens received data when set and does neither when clear, clear after reset.
// - the crc bit makes the framer append a crc on send and check it on receive, set after reset.
// - filter code 00 passes every packet and is the reset choice, code 01 passes only the node address.
// - filter code 10 passes the node address and 0x00 and rejects the rest.
// - filter code 11 passes the node address, 0x00 and 0xFF and rejects the rest.
// - bit 0 of the packet configuration is read-only and shows whether the last packet's crc passed.
// - the packet configuration reads 0x48 after reset.
// - the seven-bit payload length is the exact length for receive and send in fixed format and the receive maximum in variable format.
// - with the auto-clear bit at zero, its reset value, a packet whose crc fails is removed from the fifo; a one keeps it.
`timescale 1ns/100ps
module rph_top import rph_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // receive byte stream from the demodulator
  input wire rph_rx_s rx_in,
  // transmit byte stream to the modulator
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  output logic tx_active
);
  rph_pfc_s pfc_r;
  logic crc_ok_r;
  logic [7:0] node_r;
  logic [6:0] plen_r;
  logic plen_b7_r;
  logic autoclr_dis_r;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] mask_r;
  logic [6:0] tx_len_r;
  logic [31:0] prdata_r;

  // apb decode: zero wait states, pready always high
  logic setup;
  logic acc;
  logic wr;
  logic lane0;
  logic mapped;
  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign lane0 = pstrb[0];
  assign mapped = (paddr == OFS_PAYLOAD_LEN) || (paddr == OFS_NODE_ADDR) ||
                  (paddr == OFS_PKT_CFG) || (paddr == OFS_FIFO_CRC) ||
                  (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK) ||
                  (paddr == OFS_RX_DATA) || (paddr == OFS_TX_DATA) ||
                  (paddr == OFS_TX_CTRL) || (paddr == OFS_FIFO_LVL);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_r <= RST_NODE_ADDR;
      pfc_r <= rph_pfc_s'(RST_PKT_CFG[7:1]);
      {plen_b7_r, plen_r} <= RST_PAYLOAD_LEN;
      autoclr_dis_r <= RST_FIFO_CRC[FIFO_CRC_AUTOCLR_BIT];
      mask_r <= RST_IRQ;
      tx_len_r <= RST_TX_LEN;
    end else if (wr) begin
      if (paddr == OFS_NODE_ADDR && lane0) begin
        node_r <= pwdata[7:0];
      end
      if (paddr == OFS_PKT_CFG && lane0) begin
        pfc_r <= rph_pfc_s'(pwdata[7:1]);
      end
      if (paddr == OFS_PAYLOAD_LEN && lane0) begin
        {plen_b7_r, plen_r} <= pwdata[7:0];
      end
      if (paddr == OFS_FIFO_CRC && lane0) begin
        autoclr_dis_r <= pwdata[FIFO_CRC_AUTOCLR_BIT];
      end
      if (paddr == OFS_IRQ_MASK && lane0) begin
        mask_r <= pwdata[IRQ_W-1:0];
      end
      if (paddr == OFS_TX_CTRL && pstrb[1]) begin
        tx_len_r <= pwdata[14:8];
      end
    end
  end

  // receive fifo pointers; readable data stops at the committed pointer
  logic [FIFO_AW:0] wr_r;
  logic [FIFO_AW:0] commit_r;
  logic [FIFO_AW:0] commit_d_r;
  logic [FIFO_AW:0] rd_r;
  logic [FIFO_AW:0] rd_nxt;
  logic [7:0] mem_dout;
  logic rx_empty;
  logic pop;
  assign rx_empty = (rd_r == commit_d_r);
  assign pop = acc && !pwrite && (paddr == OFS_RX_DATA) && !rx_empty;
  assign rd_nxt = pop ? rd_r + 7'h01 : rd_r;

  // receive framer decisions
  rph_rx_e rx_st_r;
  rph_rx_e rx_st_nxt;
  rph_rx_e st_eff;
  logic [6:0] rx_rem_r;
  logic [6:0] rx_rem_nxt;
  logic [6:0] rem_eff;
  logic rx_first_r;
  logic first_eff;
  logic [8:0] rx_lf_r;
  logic [8:0] lf_eff;
  logic [15:0] rx_crc_r;
  logic [15:0] crc_eff;
  logic [7:0] rx_hi_r;
  logic [7:0] rx_d;
  logic [FIFO_AW:0] wr_base;
  logic rx_we;
  logic rx_rollback;
  logic rx_commit;
  logic rx_fin;
  logic rx_pass;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    st_eff = rx_st_r;
    rem_eff = rx_rem_r;
    first_eff = rx_first_r;
    lf_eff = rx_lf_r;
    crc_eff = rx_crc_r;
    wr_base = wr_r;
    if (rx_in.sof) begin
      // a new frame abandons any frame in progress
      st_eff = RX_BODY;
      rem_eff = plen_r;
      first_eff = 1'b1;
      lf_eff = PN9_SEED;
      crc_eff = CRC_SEED;
      wr_base = commit_r;
    end
    rx_d = pfc_r.whitening_enable ? rx_in.data ^ lf_eff[7:0]
                                  : rx_in.data;
    rx_st_nxt = rx_in.sof ? RX_IDLE : rx_st_r;
    rx_rem_nxt = rem_eff;
    rx_we = 1'b0;
    rx_rollback = rx_in.sof && (rx_st_r != RX_IDLE);
    rx_commit = 1'b0;
    rx_fin = 1'b0;
    rx_pass = 1'b1;
    ev = '0;
    if (rx_in.valid) begin
      if (rx_in.sof && pfc_r.length_format_sel) begin
        // length byte: zero or above the maximum is refused
        if (rx_d == 8'h00 || rx_d > {1'b0, plen_r}) begin
          ev[IRQ_RX_REJECT] = 1'b1;
        end else if ((wr_base - rd_r) == FIFO_DEPTH) begin
          ev[IRQ_RX_OVERFLOW] = 1'b1;
        end else begin
          rx_we = 1'b1;
          rx_rem_nxt = rx_d[6:0];
          rx_st_nxt = RX_BODY;
        end
      end else begin
        case (st_eff)
          RX_IDLE: rx_st_nxt = RX_IDLE;
          RX_BODY: begin
            if (rem_eff == 7'h00) begin
              ev[IRQ_RX_REJECT] = 1'b1;
              rx_rollback = 1'b1;
              rx_st_nxt = RX_IDLE;
            end else if (first_eff &&
                         !addr_ok(pfc_r.address_filter_mode, node_r,
                                  rx_d)) begin
              ev[IRQ_RX_REJECT] = 1'b1;
              rx_rollback = 1'b1;
              rx_st_nxt = RX_IDLE;
            end else if ((wr_base - rd_r) == FIFO_DEPTH) begin
              ev[IRQ_RX_OVERFLOW] = 1'b1;
              rx_rollback = 1'b1;
              rx_st_nxt = RX_IDLE;
            end else begin
              rx_we = 1'b1;
              rx_rem_nxt = rem_eff - 7'h01;
              rx_st_nxt = RX_BODY;
              if (rem_eff == 7'h01) begin
                if (pfc_r.crc_check_enable) begin
                  rx_st_nxt = RX_CRC_HI;
                end else begin
                  rx_st_nxt = RX_IDLE;
                  rx_commit = 1'b1;
                  rx_fin = 1'b1;
                  ev[IRQ_RX_DONE] = 1'b1;
                end
              end
            end
          end
          RX_CRC_HI: rx_st_nxt = RX_CRC_LO;
          RX_CRC_LO: begin
            rx_st_nxt = RX_IDLE;
            rx_fin = 1'b1;
            rx_pass = ({rx_hi_r, rx_d} == rx_crc_r);
            ev[IRQ_RX_DONE] = 1'b1;
            ev[IRQ_RX_CRC_FAIL] = !rx_pass;
            // a failed packet is dropped unless auto-clear is disabled
            if (rx_pass || autoclr_dis_r) begin
              rx_commit = 1'b1;
            end else begin
              rx_rollback = 1'b1;
            end
          end
          default: rx_st_nxt = RX_IDLE;
        endcase
      end
    end
  end

  // receive framer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_rem_r <= 7'h00;
      rx_first_r <= 1'b0;
      rx_lf_r <= PN9_SEED;
      rx_crc_r <= CRC_SEED;
      rx_hi_r <= 8'h00;
    end else if (rx_in.valid || rx_in.sof) begin
      rx_st_r <= rx_st_nxt;
      rx_rem_r <= rx_rem_nxt;
      if (rx_in.valid) begin
        rx_lf_r <= pn9_next8(lf_eff);
        rx_first_r <= first_eff && !(st_eff == RX_BODY && rx_we &&
                      !(rx_in.sof && pfc_r.length_format_sel));
        rx_hi_r <= rx_d;
        if (st_eff == RX_BODY || rx_in.sof) begin
          rx_crc_r <= crc16_byte(crc_eff, rx_d);
        end else begin
          rx_crc_r <= crc_eff;
        end
      end
    end
  end

  // fifo pointer updates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_r <= '0;
      commit_r <= '0;
      commit_d_r <= '0;
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
      // visibility lags a cycle so the memory read register catches up
      commit_d_r <= commit_r;
      if (rx_rollback) begin
        wr_r <= (rx_in.sof && rx_we) ? commit_r + 7'h01 : commit_r;
      end else if (rx_we) begin
        wr_r <= wr_base + 7'h01;
      end else begin
        wr_r <= wr_base;
      end
      if (rx_commit) begin
        commit_r <= rx_we ? wr_base + 7'h01 : wr_base;
      end
    end
  end

  rph_mem u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(rx_we),
    .waddr(wr_base[FIFO_AW-1:0]),
    .wdata(rx_d),
    .raddr(rd_nxt[FIFO_AW-1:0]),
    .rdata(mem_dout)
  );

  // crc outcome of the last finished packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_ok_r <= RST_PKT_CFG[0];
    end else if (rx_fin) begin
      crc_ok_r <= rx_pass;
    end
  end

  // transmit holding register and framer
  rph_tx_e tx_st_r;
  logic [7:0] hold_r;
  logic hold_full_r;
  logic [2:0] pre_cnt_r;
  logic [6:0] tx_rem_r;
  logic [8:0] tx_lf_r;
  logic [15:0] tx_crc_r;
  logic tx_valid_r;
  logic [7:0] tx_byte_r;
  logic slot;
  logic start;
  logic hold_wr;
  logic tx_take;
  logic [7:0] tx_plain;
  assign slot = !tx_valid_r || tx_ready;
  assign start = wr && (paddr == OFS_TX_CTRL) && lane0 &&
                 pwdata[TX_CTRL_START_BIT] && (tx_st_r == TX_IDLE);
  assign hold_wr = wr && (paddr == OFS_TX_DATA) && lane0 && !hold_full_r;
  assign tx_take = slot && (tx_st_r == TX_BODY) && hold_full_r && |tx_rem_r;
  assign tx_plain = (tx_st_r == TX_LEN) ? {1'b0, tx_rem_r} :
                    (tx_st_r == TX_CRC_HI) ? tx_crc_r[15:8] :
                    (tx_st_r == TX_CRC_LO) ? tx_crc_r[7:0] : hold_r;
  assign tx_valid = tx_valid_r;
  assign tx_byte = tx_byte_r;
  assign tx_active = (tx_st_r != TX_IDLE) || tx_valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
    end else if (hold_wr) begin
      hold_r <= pwdata[7:0];
      hold_full_r <= 1'b1;
    end else if (tx_take) begin
      hold_full_r <= 1'b0;
    end
  end

  logic tx_emit;
  logic tx_last;
  logic tx_done_ev;
  assign tx_emit = slot && (tx_st_r != TX_IDLE) && (tx_st_r != TX_BODY ||
                   (hold_full_r && tx_rem_r != 7'h00));
  assign tx_last = (tx_st_r == TX_CRC_LO) ||
                   (tx_st_r == TX_BODY && tx_rem_r == 7'h01 &&
                    !pfc_r.crc_check_enable);
  assign tx_done_ev = tx_emit && tx_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_r <= TX_IDLE;
      pre_cnt_r <= 3'h0;
      tx_rem_r <= 7'h00;
      tx_lf_r <= PN9_SEED;
      tx_crc_r <= CRC_SEED;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      if (tx_ready) begin
        tx_valid_r <= 1'b0;
      end
      if (start) begin
        tx_st_r <= TX_PRE;
        pre_cnt_r <= {1'b0, pfc_r.preamble_byte_count} + 3'h1;
      end else if (tx_emit) begin
        tx_valid_r <= 1'b1;
        if (tx_st_r == TX_PRE) begin
          tx_byte_r <= PREAMBLE_BYTE;
          pre_cnt_r <= pre_cnt_r - 3'h1;
          if (pre_cnt_r == 3'h1) begin
            tx_lf_r <= PN9_SEED;
            tx_crc_r <= CRC_SEED;
            // variable format sends its own length, not the fixed one
            tx_rem_r <= pfc_r.length_format_sel ? tx_len_r
                                                : plen_r;
            tx_st_r <= pfc_r.length_format_sel ? TX_LEN : TX_BODY;
          end
        end else begin
          tx_byte_r <= pfc_r.whitening_enable ? tx_plain ^ tx_lf_r[7:0]
                                              : tx_plain;
          tx_lf_r <= pn9_next8(tx_lf_r);
          if (tx_st_r == TX_LEN || tx_st_r == TX_BODY) begin
            tx_crc_r <= crc16_byte(tx_crc_r, tx_plain);
          end
          case (tx_st_r)
            TX_LEN: tx_st_r <= TX_BODY;
            TX_BODY: begin
              tx_rem_r <= tx_rem_r - 7'h01;
              if (tx_rem_r == 7'h01) begin
                tx_st_r <= pfc_r.crc_check_enable ? TX_CRC_HI
                                                  : TX_IDLE;
              end
            end
            TX_CRC_HI: tx_st_r <= TX_CRC_LO;
            TX_CRC_LO: tx_st_r <= TX_IDLE;
            default: tx_st_r <= TX_IDLE;
          endcase
        end
      end else if (tx_st_r == TX_BODY && tx_rem_r == 7'h00) begin
        tx_st_r <= TX_IDLE;
      end
    end
  end

  // sticky interrupt status, write one to clear, a new event wins
  logic [IRQ_W-1:0] ev_all;
  logic [IRQ_W-1:0] w1c;
  assign ev_all = ev | ({IRQ_W{tx_done_ev}} & (6'h01 << IRQ_TX_DONE)) |
                  ({IRQ_W{tx_take}} & (6'h01 << IRQ_TX_HOLD_EMPTY));
  assign w1c = (wr && paddr == OFS_IRQ_STAT && lane0) ? pwdata[IRQ_W-1:0]
                                                      : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= RST_IRQ;
    end else begin
      stat_r <= (stat_r & ~w1c) | ev_all;
    end
  end
  assign irq = |(stat_r & mask_r);

  // read data captured in the setup cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_PAYLOAD_LEN: rd_mux = {24'h000000, plen_b7_r, plen_r};
      OFS_NODE_ADDR: rd_mux = {24'h000000, node_r};
      OFS_PKT_CFG: rd_mux = {24'h000000, pfc_r, crc_ok_r};
      OFS_FIFO_CRC: rd_mux = {24'h000000, autoclr_dis_r, 7'h00};
      OFS_IRQ_STAT: rd_mux = {26'h0000000, stat_r};
      OFS_IRQ_MASK: rd_mux = {26'h0000000, mask_r};
      OFS_RX_DATA: rd_mux = {23'h000000, rx_empty, mem_dout};
      OFS_TX_DATA: rd_mux = {23'h000000, hold_full_r, hold_r};
      OFS_TX_CTRL: rd_mux = {17'h00000, tx_len_r, 7'h00, tx_active};
      OFS_FIFO_LVL: rd_mux = {25'h0000000, commit_d_r - rd_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end
endmodule

// *** hdl/rph_pkg.sv ***
package rph_pkg;
  // register indices and byte addresses (index times four)
  localparam logic [7:0] IDX_PAYLOAD_LEN = 8'h1c;
  localparam logic [7:0] IDX_NODE_ADDR = 8'h1d;
  localparam logic [7:0] IDX_PKT_CFG = 8'h1e;
  localparam logic [7:0] IDX_FIFO_CRC = 8'h1f;
  localparam logic [7:0] OFS_PAYLOAD_LEN = {IDX_PAYLOAD_LEN[5:0], 2'b00};
  localparam logic [7:0] OFS_NODE_ADDR = {IDX_NODE_ADDR[5:0], 2'b00};
  localparam logic [7:0] OFS_PKT_CFG = {IDX_PKT_CFG[5:0], 2'b00};
  localparam logic [7:0] OFS_FIFO_CRC = {IDX_FIFO_CRC[5:0], 2'b00};
  localparam logic [7:0] OFS_IRQ_STAT = 8'h80;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h84;
  localparam logic [7:0] OFS_RX_DATA = 8'h88;
  localparam logic [7:0] OFS_TX_DATA = 8'h8c;
  localparam logic [7:0] OFS_TX_CTRL = 8'h90;
  localparam logic [7:0] OFS_FIFO_LVL = 8'h94;

  // reset values
  localparam logic [7:0] RST_PAYLOAD_LEN = 8'h00;
  localparam logic [7:0] RST_NODE_ADDR = 8'h00;
  localparam logic [7:0] RST_PKT_CFG = 8'h48;
  localparam logic [7:0] RST_FIFO_CRC = 8'h00;
  localparam logic [6:0] RST_TX_LEN = 7'h00;
  localparam logic [5:0] RST_IRQ = 6'h00;

  // field positions
  localparam int unsigned FIFO_CRC_AUTOCLR_BIT = 7;
  localparam int unsigned TX_CTRL_START_BIT = 0;
  localparam int unsigned RX_DATA_EMPTY_BIT = 8;

  // interrupt status layout
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_RX_DONE = 0;
  localparam int unsigned IRQ_RX_CRC_FAIL = 1;
  localparam int unsigned IRQ_RX_REJECT = 2;
  localparam int unsigned IRQ_RX_OVERFLOW = 3;
  localparam int unsigned IRQ_TX_DONE = 4;
  localparam int unsigned IRQ_TX_HOLD_EMPTY = 5;

  // framing constants
  localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  localparam logic [7:0] ADDR_BCAST = 8'hff;

  // receive fifo
  localparam int unsigned FIFO_AW = 6;
  localparam logic [FIFO_AW:0] FIFO_DEPTH = 7'h40;

  typedef enum logic [1:0] {
    FILT_OFF, FILT_NODE, FILT_NODE_ZERO, FILT_NODE_ZERO_BCAST
  } rph_filt_e;

  // packet configuration, bit 7 down to bit 1
  typedef struct packed {
    logic length_format_sel;
    logic [1:0] preamble_byte_count;
    logic whitening_enable;
    logic crc_check_enable;
    rph_filt_e address_filter_mode;
  } rph_pfc_s;

  typedef struct packed {
    logic sof;
    logic valid;
    logic [7:0] data;
  } rph_rx_s;

  typedef enum {RX_IDLE, RX_BODY, RX_CRC_HI, RX_CRC_LO} rph_rx_e;
  typedef enum {TX_IDLE, TX_PRE, TX_LEN, TX_BODY, TX_CRC_HI, TX_CRC_LO}
    rph_tx_e;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [8:0] pn9_next8(input logic [8:0] s);
    logic [8:0] r;
    r = s;
    for (int i = 0; i < 8; i++) begin
      r = {r[0] ^ r[5], r[8:1]};
    end
    return r;
  endfunction

  function automatic logic addr_ok(input rph_filt_e m, input logic [7:0] node,
                                   input logic [7:0] a);
    logic r;
    r = 1'b1;
    case (m)
      FILT_OFF: r = 1'b1;
      FILT_NODE: r = (a == node);
      FILT_NODE_ZERO: r = (a == node) || (a == ADDR_ZERO);
      FILT_NODE_ZERO_BCAST: r = (a == node) || (a == ADDR_ZERO) ||
                                (a == ADDR_BCAST);
      default: r = 1'b1;
    endcase
    return r;
  endfunction
endpackage

// *** hdl/rph_mem.sv ***
`timescale 1ns/100ps
module rph_mem import rph_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic we,
  input wire logic [FIFO_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [FIFO_AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [2**FIFO_AW];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// *** verif/rph_props.sv ***
`timescale 1ns/100ps
module rph_props import rph_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb and interrupt
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  input wire logic tx_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, wr, mapped;
  logic [7:0] node_r;
  logic [7:1] cfg_r;
  logic [5:0] mask_r;
  logic [3:0] cnt_r;
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign mapped = paddr >= 8'h70 && paddr <= 8'h94 && paddr[1:0] == 2'b00;
  // shadows of software writes, so readback can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_r <= RST_NODE_ADDR;
      cfg_r <= RST_PKT_CFG[7:1];
      mask_r <= RST_IRQ;
    end else if (wr) begin
      if (paddr == OFS_NODE_ADDR) node_r <= pwdata[7:0];
      if (paddr == OFS_PKT_CFG) cfg_r <= pwdata[7:1];
      if (paddr == OFS_IRQ_MASK) mask_r <= pwdata[5:0];
    end
  end
  // bytes taken in the current frame, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 4'h0;
    else if (!tx_active) cnt_r <= 4'h0;
    else if (tx_valid && tx_ready && cnt_r != 4'hf) cnt_r <= cnt_r + 4'h1;
  end
  sequence s_rd(logic [7:0] a);
    acc && !pwrite && paddr == a;
  endsequence
  sequence s_start;
    wr && paddr == OFS_TX_CTRL && pwdata[0] && !tx_active;
  endsequence
  a_node_read:
    assert property (s_rd(OFS_NODE_ADDR) |-> prdata == {24'h0, node_r})
      else $error("node address readback wrong");
  a_cfg_read:
    assert property (s_rd(OFS_PKT_CFG) |-> prdata[31:1] == {24'h0, cfg_r})
      else $error("packet config readback wrong");
  a_unmapped_err:
    assert property (acc && !mapped |-> pslverr)
      else $error("unmapped access without error");
  a_mapped_ok:
    assert property (acc && mapped |-> pready && !pslverr)
      else $error("mapped access not clean");
  a_preamble_lead:
    assert property ($rose(tx_active) |-> ##[0:1]
      (tx_valid && tx_byte == PREAMBLE_BYTE))
      else $error("frame not led by preamble");
  a_preamble_bytes:
    assert property (tx_valid && tx_ready && cnt_r <= {2'b00, cfg_r[6:5]}
      |-> tx_byte == PREAMBLE_BYTE) else $error("preamble too short");
  a_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
      else $error("tx byte dropped while stalled");
  a_irq_masked:
    assert property (mask_r == 6'h00 |-> !irq)
      else $error("irq with all sources masked");
  a_start_busy:
    assert property (s_start |=> tx_active) else $error("start ignored");
endmodule

// *** verif/rph_radio_model.sv ***
`timescale 1ns/100ps
module rph_radio_model import rph_pkg::*; (
  // clock
  input wire logic pclk,
  // air side
  output rph_rx_s rx_in,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic slow = 1'b0;
  int cnt = 0;
  logic [7:0] last, prev;
  initial begin
    rx_in = '{1'b0, 1'b0, 8'h00};
    tx_ready = 1'b0;
  end
  // a slow radio accepts only every other cycle
  always @(posedge pclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      prev <= last;
      last <= tx_byte;
      cnt <= cnt + 1;
    end
  end
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      rx_in <= '{i == 0, 1'b1, b[i]};
      @(posedge pclk);
    end
    // junk between frames so stale data never passes as a byte
    rx_in <= '{1'b0, 1'b0, ~b[b.size()-1]};
  endtask
endmodule

// *** verif/rph_top_bench.sv ***
`timescale 1ns/100ps
module rph_top_bench import rph_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, tx_valid, tx_ready, tx_active, err;
  logic [7:0] tx_byte;
  rph_rx_s rx_in;
  int errors = 0;
  int n_checks = 0;
  always #4 pclk = ~pclk;
  rph_top rph_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .rx_in(rx_in), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .tx_active(tx_active));
  rph_radio_model radio_i (.pclk(pclk), .rx_in(rx_in), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_ready(tx_ready));
  function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge pclk);
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 32'h0, 1'b0);
    chk(q, e);
  endtask
  task automatic t_regs();
    rd_chk(OFS_PKT_CFG, 32'h48);
    rd_chk(OFS_NODE_ADDR, 32'h0);
    apb(OFS_NODE_ADDR, 32'h5a, 1'b1);
    rd_chk(OFS_NODE_ADDR, 32'h5a);
    apb(OFS_PKT_CFG, 32'hff, 1'b1);
    rd_chk(OFS_PKT_CFG, 32'hfe);
    rd_chk(8'h40, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_filter();
    logic [7:0] a;
    logic ok;
    apb(OFS_PAYLOAD_LEN, 32'h02, 1'b1);
    apb(OFS_IRQ_MASK, 32'h01, 1'b1);
    for (int m = 0; m < 4; m++) begin
      apb(OFS_PKT_CFG, 32'h40 | (m << 1), 1'b1);
      for (int i = 0; i < 4; i++) begin
        a = (i == 0) ? 8'h5a : (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'h33;
        ok = m == 0 || a == 8'h5a || (m > 1 && a == 8'h00) ||
          (m == 3 && a == 8'hff);
        radio_i.send({a, 8'h11});
        repeat (4) @(posedge pclk);
        chk(irq, ok);
        rd_chk(OFS_IRQ_STAT, {29'h0, !ok, 1'b0, ok});
        apb(OFS_IRQ_STAT, 32'h3f, 1'b1);
      end
    end
    rd_chk(OFS_FIFO_LVL, 32'd20);
  endtask
  task automatic t_crc();
    logic [15:0] c;
    c = crc_add(crc_add(CRC_SEED, 8'h5a), 8'h22);
    apb(OFS_PKT_CFG, 32'h48, 1'b1);
    radio_i.send({8'h5a, 8'h22, c[15:8], c[7:0]});
    repeat (4) @(posedge pclk);
    rd_chk(OFS_PKT_CFG, 32'h49);
    for (int k = 0; k < 2; k++) begin
      apb(OFS_FIFO_CRC, k << 7, 1'b1);
      radio_i.send({8'h5a, 8'h22, c[15:8], ~c[7:0]});
      repeat (4) @(posedge pclk);
      rd_chk(OFS_PKT_CFG, 32'h48);
      rd_chk(OFS_FIFO_LVL, 32'd22 + 2 * k);
    end
    apb(OFS_PKT_CFG, 32'hc0, 1'b1);
    for (int n = 3; n > 1; n--) begin
      radio_i.send({n[7:0], 8'h5a, 8'h22});
      repeat (4) @(posedge pclk);
      rd_chk(OFS_FIFO_LVL, (n == 3) ? 32'd24 : 32'd27);
    end
  endtask
  task automatic t_tx();
    int n0;
    logic v, w, e;
    logic [15:0] s;
    s = crc_add(CRC_SEED, 8'h3c);
    apb(OFS_PAYLOAD_LEN, 32'h01, 1'b1);
    for (int k = 0; k < 4; k++) begin
      v = (k == 3);
      w = (k == 1);
      e = (k == 2);
      radio_i.slow <= k[0];
      apb(OFS_PKT_CFG, {v, k[1:0], w, e, 3'h0}, 1'b1);
      apb(OFS_TX_DATA, 32'h3c, 1'b1);
      n0 = radio_i.cnt;
      apb(OFS_TX_CTRL, 32'h0101, 1'b1);
      repeat (2) @(posedge pclk);
      while (tx_active) @(posedge pclk);
      chk(radio_i.cnt - n0, k + 2 + v + 2 * e);
      chk(radio_i.prev, v ? 8'h01 : e ? s[15:8] : 8'haa);
      chk(radio_i.last, w ? 8'hc3 : e ? s[7:0] : 8'h3c);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_filter();
    t_crc();
    t_tx();
    report_and_stop();
  end
  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
endmodule
bind rph_top rph_props rph_props_i (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .tx_active(tx_active));
